// file: rtl/hq_defs.svh
// Constants for the retransmission control block.
`ifndef HQ_DEFS_SVH
`define HQ_DEFS_SVH
`define HQ_OFF_CTRL 8'h00
`define HQ_OFF_MAXRETX 8'h04
`define HQ_OFF_UNITTHR 8'h08
`define HQ_OFF_OCTTHR 8'h0c
`define HQ_OFF_TMR 8'h10
`define HQ_OFF_PROH 8'h14
`define HQ_OFF_POLLST 8'h18
`define HQ_OFF_CNTST 8'h1c
`define HQ_RST_MAXRETX 4'h4
`define HQ_RST_UNITTHR 16'h0010
`define HQ_RST_OCTTHR 16'h1000
`define HQ_RST_TMR 16'h0100
`define HQ_RST_PROH 16'h0040
`define HQ_SN_W 10
`define HQ_SO_W 15
`define HQ_CPT_STATUS 3'h0
`define HQ_DC_CTRL 1'b0
`define HQ_RPT_W 64
`define HQ_BYTES_ACK 4'h2
`define HQ_BYTES_NACK 4'h4
`define HQ_BYTES_SO 4'h8
`define HQ_RESP_OK 2'h0
`define HQ_RESP_ERR 2'h2
`endif

// file: rtl/hq_pkg.sv
// Types shared by the retransmission control block.
`default_nettype none
package hq_pkg;
   typedef enum logic [2:0] {
      HQ_ACT_NONE, HQ_ACT_NEW, HQ_ACT_ADAPT, HQ_ACT_NONADAPT, HQ_ACT_HOLD, HQ_ACT_SKIP
   } hq_ul_act_t;
endpackage
`default_nettype wire

// file: rtl/hq_retx_ctrl.sv
// Hybrid decision, poll logic, segment cutter and status report builder with AXI4-Lite.
//
// The AXI4-Lite interface to the registers and the placing of the registers were decided locally.
`include "hq_defs.svh"
`default_nettype none
module hq_retx_ctrl import hq_pkg::*; #(
   parameter int PROCS = 8,
   parameter int PW = 3,
   parameter logic [15:0] HDR_OCTETS = 16'h0004
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic harq_decide,
   input wire logic ul_grant_valid,
   input wire logic ul_grant_new,
   input wire logic [PW-1:0] ul_grant_proc,
   input wire logic [PW-1:0] ul_sync_proc,
   input wire logic ul_feedback_nack,
   input wire logic meas_gap,
   output hq_ul_act_t ul_act,
   output logic ul_act_valid,
   output logic [PW-1:0] ul_act_proc,
   input wire logic dl_grant_valid,
   input wire logic dl_grant_retx,
   input wire logic [PW-1:0] dl_grant_proc,
   output logic dl_sched_valid,
   output logic dl_sched_retx,
   output logic [PW-1:0] dl_sched_proc,
   input wire logic dl_decode_done,
   input wire logic dl_decode_ok,
   input wire logic ul_data_sched,
   output logic dl_fb_valid,
   output logic dl_fb_ack,
   output logic dl_fb_on_extra,
   input wire logic unit_sent,
   input wire logic [15:0] unit_len,
   input wire logic unit_bufs_empty,
   input wire logic unit_window_stall,
   output logic unit_poll,
   output logic [`HQ_SN_W-1:0] unit_seqnum,
   output logic poll_timer_expired,
   input wire logic nack_from_report,
   input wire logic [`HQ_SO_W-1:0] nack_first,
   input wire logic [`HQ_SO_W-1:0] nack_last,
   input wire logic tx_opp,
   input wire logic [15:0] tx_opp_octets,
   output logic seg_valid,
   output logic [`HQ_SO_W-1:0] seg_first,
   output logic [`HQ_SO_W-1:0] seg_last,
   output logic seg_poll,
   input wire logic rx_peer_poll,
   input wire logic rx_missing,
   input wire logic [`HQ_SN_W-1:0] rx_missing_sn,
   input wire logic rx_missing_has_so,
   input wire logic [`HQ_SO_W-1:0] rx_so_first,
   input wire logic [`HQ_SO_W-1:0] rx_so_last,
   input wire logic [`HQ_SN_W-1:0] rx_ack_seqnum,
   output logic [7:0] rpt_data,
   output logic rpt_valid,
   output logic rpt_last,
   input wire logic rpt_ready
);
   function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                         input logic [3:0] s);
      logic [31:0] r;
      r = o;
      for (int i = 0; i < 4; i++) begin
         if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
      end
      return r;
   endfunction

   // Register bus: one write and one read outstanding; address and data taken in any order.
   logic aw_hold_r, w_hold_r, bvalid_r, rvalid_r;
   logic [7:0] aw_addr_r;
   logic [31:0] w_data_r, rdata_r;
   logic [3:0] w_strb_r;
   logic [1:0] bresp_r, rresp_r;
   logic wr_fire;
   logic prohibit_en_r;
   logic [3:0] max_retx_r;
   logic [15:0] unit_thr_r, octet_thr_r, tmr_load_r, proh_load_r;
   logic [15:0] units_cnt_r, octets_cnt_r, tmr_r, proh_r;
   logic [`HQ_SN_W-1:0] next_send_r, requested_r;

   assign s_axi_awready = !aw_hold_r && !bvalid_r;
   assign s_axi_wready = !w_hold_r && !bvalid_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign wr_fire = aw_hold_r && w_hold_r && !bvalid_r;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         bvalid_r <= 1'b0;
         aw_addr_r <= 8'h00;
         w_data_r <= 32'h0000_0000;
         w_strb_r <= 4'h0;
         bresp_r <= `HQ_RESP_OK;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_r <= 1'b1;
            aw_addr_r <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_r <= 1'b1;
            w_data_r <= s_axi_wdata;
            w_strb_r <= s_axi_wstrb;
         end
         if (wr_fire) begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= (aw_addr_r <= `HQ_OFF_CNTST && aw_addr_r[1:0] == 2'h0) ?
                       `HQ_RESP_OK : `HQ_RESP_ERR;
         end else if (bvalid_r && s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Old contents of the addressed register, so that byte strobes leave unselected lanes alone.
   logic [31:0] wr_old, wr_new;
   always_comb begin
      unique case (aw_addr_r)
         `HQ_OFF_CTRL: wr_old = {31'h0, prohibit_en_r};
         `HQ_OFF_MAXRETX: wr_old = {28'h0, max_retx_r};
         `HQ_OFF_UNITTHR: wr_old = {16'h0, unit_thr_r};
         `HQ_OFF_OCTTHR: wr_old = {16'h0, octet_thr_r};
         `HQ_OFF_TMR: wr_old = {16'h0, tmr_load_r};
         `HQ_OFF_PROH: wr_old = {16'h0, proh_load_r};
         default: wr_old = 32'h0000_0000;
      endcase
   end
   assign wr_new = merge(wr_old, w_data_r, w_strb_r);

   // The status-prohibit option is kept per entity by the higher layer.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         prohibit_en_r <= 1'b0;
         max_retx_r <= `HQ_RST_MAXRETX;
         unit_thr_r <= `HQ_RST_UNITTHR;
         octet_thr_r <= `HQ_RST_OCTTHR;
         tmr_load_r <= `HQ_RST_TMR;
         proh_load_r <= `HQ_RST_PROH;
      end else if (wr_fire) begin
         unique case (aw_addr_r)
            `HQ_OFF_CTRL: prohibit_en_r <= wr_new[0];
            `HQ_OFF_MAXRETX: max_retx_r <= wr_new[3:0];
            `HQ_OFF_UNITTHR: unit_thr_r <= wr_new[15:0];
            `HQ_OFF_OCTTHR: octet_thr_r <= wr_new[15:0];
            `HQ_OFF_TMR: tmr_load_r <= wr_new[15:0];
            `HQ_OFF_PROH: proh_load_r <= wr_new[15:0];
            default: ;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= `HQ_RESP_OK;
      end else if (s_axi_arvalid && s_axi_arready) begin
         rvalid_r <= 1'b1;
         rresp_r <= `HQ_RESP_OK;
         unique case (s_axi_araddr)
            `HQ_OFF_CTRL: rdata_r <= {31'h0, prohibit_en_r};
            `HQ_OFF_MAXRETX: rdata_r <= {28'h0, max_retx_r};
            `HQ_OFF_UNITTHR: rdata_r <= {16'h0, unit_thr_r};
            `HQ_OFF_OCTTHR: rdata_r <= {16'h0, octet_thr_r};
            `HQ_OFF_TMR: rdata_r <= {16'h0, tmr_load_r};
            `HQ_OFF_PROH: rdata_r <= {16'h0, proh_load_r};
            `HQ_OFF_POLLST: rdata_r <= {tmr_r, 6'h0, requested_r};
            `HQ_OFF_CNTST: rdata_r <= {units_cnt_r, octets_cnt_r};
            default: begin
               rdata_r <= 32'h0000_0000;
               rresp_r <= `HQ_RESP_ERR;
            end
         endcase
      end else if (rvalid_r && s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Uplink decision. One limit for the whole station, counted per process.
   logic [3:0] retx_cnt_r [PROCS];
   logic [PW-1:0] dec_proc;
   hq_ul_act_t dec_act;
   assign dec_proc = ul_grant_valid ? ul_grant_proc : ul_sync_proc;

   always_comb begin
      if (ul_grant_valid) begin
         dec_act = ul_grant_new ? HQ_ACT_NEW : HQ_ACT_ADAPT;
      end else if (ul_feedback_nack && retx_cnt_r[ul_sync_proc] < max_retx_r) begin
         dec_act = HQ_ACT_NONADAPT;
      end else begin
         dec_act = HQ_ACT_HOLD;
      end
      // A gap always beats a retransmission, granted or not.
      if (meas_gap && (dec_act == HQ_ACT_ADAPT || dec_act == HQ_ACT_NONADAPT)) begin
         dec_act = HQ_ACT_SKIP;
      end
   end

   for (genvar p = 0; p < PROCS; p++) begin : g_proc
      always_ff @(posedge clk or negedge rst_b) begin
         if (!rst_b) begin
            retx_cnt_r[p] <= 4'h0;
         end else if (harq_decide && dec_proc == PW'(p)) begin
            if (dec_act == HQ_ACT_NEW) retx_cnt_r[p] <= 4'h0;
            else if (dec_act == HQ_ACT_ADAPT || dec_act == HQ_ACT_NONADAPT)
               retx_cnt_r[p] <= retx_cnt_r[p] + 4'h1;
         end
      end
   end : g_proc

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ul_act <= HQ_ACT_NONE;
         ul_act_valid <= 1'b0;
         ul_act_proc <= '0;
      end else begin
         ul_act_valid <= harq_decide;
         if (harq_decide) begin
            ul_act <= dec_act;
            ul_act_proc <= dec_proc;
         end
      end
   end

   // Downlink side: only a grant can start a retransmission; feedback rides the data
   // channel when uplink data is scheduled, so the primary channel is left free.
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         dl_sched_valid <= 1'b0;
         dl_sched_retx <= 1'b0;
         dl_sched_proc <= '0;
         dl_fb_valid <= 1'b0;
         dl_fb_ack <= 1'b0;
         dl_fb_on_extra <= 1'b0;
      end else begin
         dl_sched_valid <= dl_grant_valid;
         if (dl_grant_valid) begin
            dl_sched_retx <= dl_grant_retx;
            dl_sched_proc <= dl_grant_proc;
         end
         dl_fb_valid <= dl_decode_done;
         if (dl_decode_done) begin
            dl_fb_ack <= dl_decode_ok;
            dl_fb_on_extra <= ul_data_sched;
         end
      end
   end

   // Poll decision and counters.
   logic poll_now, seg_emit;
   assign poll_now = units_cnt_r >= unit_thr_r || octets_cnt_r >= octet_thr_r
                     || unit_bufs_empty || unit_window_stall;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         units_cnt_r <= 16'h0000;
         octets_cnt_r <= 16'h0000;
         next_send_r <= '0;
         requested_r <= '0;
         unit_poll <= 1'b0;
         unit_seqnum <= '0;
      end else if (unit_sent) begin
         unit_seqnum <= next_send_r;
         next_send_r <= next_send_r + 1'b1;
         unit_poll <= poll_now;
         if (poll_now) begin
            units_cnt_r <= 16'h0000;
            octets_cnt_r <= 16'h0000;
            requested_r <= next_send_r;
         end else begin
            units_cnt_r <= units_cnt_r + 16'h0001;
            octets_cnt_r <= octets_cnt_r + unit_len;
         end
      end else if (seg_emit) begin
         // A segment carries a poll too and takes no new sequence number.
         units_cnt_r <= 16'h0000;
         octets_cnt_r <= 16'h0000;
         requested_r <= next_send_r - 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         tmr_r <= 16'h0000;
         poll_timer_expired <= 1'b0;
      end else begin
         poll_timer_expired <= tmr_r == 16'h0001;
         if ((unit_sent && poll_now) || seg_emit) tmr_r <= tmr_load_r;
         else if (tmr_r != 16'h0000) tmr_r <= tmr_r - 16'h0001;
      end
   end

   // Segment cutter: one pending portion, cut piece by piece at each opportunity with room and no unit sent.
   logic seg_act_r;
   logic [`HQ_SO_W-1:0] cut_first_r, cut_last_r, room_end;
   logic [15:0] room;
   assign room = tx_opp_octets > HDR_OCTETS ? tx_opp_octets - HDR_OCTETS : 16'h0000;
   assign room_end = cut_first_r + `HQ_SO_W'(room - 16'h0001);
   assign seg_emit = tx_opp && seg_act_r && room != 16'h0000 && !unit_sent;

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         seg_act_r <= 1'b0;
         cut_first_r <= '0;
         cut_last_r <= '0;
         seg_valid <= 1'b0;
         seg_first <= '0;
         seg_last <= '0;
         seg_poll <= 1'b0;
      end else begin
         seg_valid <= seg_emit;
         if (nack_from_report && !seg_act_r) begin
            seg_act_r <= 1'b1;
            cut_first_r <= nack_first;
            cut_last_r <= nack_last;
         end else if (seg_emit) begin
            seg_first <= cut_first_r;
            seg_poll <= 1'b1;
            if (room_end >= cut_last_r || room_end < cut_first_r) begin
               seg_last <= cut_last_r;
               seg_act_r <= 1'b0;
            end else begin
               seg_last <= room_end;
               cut_first_r <= room_end + 1'b1;
            end
         end
      end
   end

   // Status report builder and octet streamer.
   logic pend_r, nack_r, so_r, busy_r, rpt_load;
   logic [`HQ_SN_W-1:0] miss_sn_r;
   logic [`HQ_SO_W-1:0] so_first_r, so_last_r;
   logic [`HQ_RPT_W-1:0] sh_r, rpt_vec;
   logic [3:0] left_r, rpt_bytes;
   assign rpt_load = pend_r && !busy_r && !(prohibit_en_r && proh_r != 16'h0000);

   always_comb begin
      rpt_vec = '0;
      if (!nack_r) begin
         rpt_vec[`HQ_RPT_W-1 -: 15] = {`HQ_DC_CTRL, `HQ_CPT_STATUS, rx_ack_seqnum, 1'b0};
         rpt_bytes = `HQ_BYTES_ACK;
      end else if (!so_r) begin
         rpt_vec[`HQ_RPT_W-1 -: 27] = {`HQ_DC_CTRL, `HQ_CPT_STATUS, rx_ack_seqnum, 1'b1,
                                        miss_sn_r, 1'b0, 1'b0};
         rpt_bytes = `HQ_BYTES_NACK;
      end else begin
         rpt_vec[`HQ_RPT_W-1 -: 57] = {`HQ_DC_CTRL, `HQ_CPT_STATUS, rx_ack_seqnum, 1'b1,
                                        miss_sn_r, 1'b0, 1'b1, so_first_r, so_last_r};
         rpt_bytes = `HQ_BYTES_SO;
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         pend_r <= 1'b0;
         nack_r <= 1'b0;
         so_r <= 1'b0;
         miss_sn_r <= '0;
         so_first_r <= '0;
         so_last_r <= '0;
      end else begin
         // A trigger in the load cycle stays pending for the next report.
         pend_r <= (pend_r && !rpt_load) || rx_peer_poll || rx_missing;
         if (rx_missing) begin
            nack_r <= 1'b1;
            so_r <= rx_missing_has_so;
            miss_sn_r <= rx_missing_sn;
            so_first_r <= rx_so_first;
            so_last_r <= rx_so_last;
         end else if (rpt_load) begin
            nack_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         busy_r <= 1'b0;
         sh_r <= '0;
         left_r <= 4'h0;
         proh_r <= 16'h0000;
      end else begin
         if (rpt_load) begin
            busy_r <= 1'b1;
            sh_r <= rpt_vec;
            left_r <= rpt_bytes;
            proh_r <= proh_load_r;
         end else begin
            if (proh_r != 16'h0000) proh_r <= proh_r - 16'h0001;
            if (busy_r && rpt_ready) begin
               sh_r <= sh_r << 8;
               left_r <= left_r - 4'h1;
               if (left_r == 4'h1) busy_r <= 1'b0;
            end
         end
      end
   end
   assign rpt_valid = busy_r;
   assign rpt_data = sh_r[`HQ_RPT_W-1 -: 8];
   assign rpt_last = busy_r && left_r == 4'h1;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_b);
   sequence s_nogrant_nack;
      harq_decide && !ul_grant_valid && ul_feedback_nack && !meas_gap
      && retx_cnt_r[ul_sync_proc] < max_retx_r;
   endsequence
   grant_obeyed_a: assert property (harq_decide && ul_grant_valid && ul_grant_new
      |=> ul_act_valid && ul_act == HQ_ACT_NEW) else $error("grant not obeyed");
   nonadapt_retx_a: assert property (s_nogrant_nack
      |=> ul_act == HQ_ACT_NONADAPT && ul_act_proc == $past(ul_sync_proc))
      else $error("no non-adaptive retransmission");
   ack_hold_a: assert property (harq_decide && !ul_grant_valid && !ul_feedback_nack
      |=> ul_act == HQ_ACT_HOLD) else $error("positive feedback did not hold");
   gap_skip_a: assert property (harq_decide && meas_gap && !(ul_grant_valid && ul_grant_new)
      |=> ul_act != HQ_ACT_NONADAPT && ul_act != HQ_ACT_ADAPT)
      else $error("retransmission inside gap");
   dl_grant_fields_a: assert property (dl_grant_valid
      |=> dl_sched_valid && dl_sched_proc == $past(dl_grant_proc))
      else $error("downlink grant fields lost");
   poll_clear_a: assert property (unit_sent && poll_now
      |=> unit_poll && units_cnt_r == 16'h0000 && octets_cnt_r == 16'h0000)
      else $error("poll did not clear counters");
   poll_seqnum_a: assert property (unit_sent && poll_now
      |=> requested_r == $past(next_send_r) && tmr_r == $past(tmr_load_r)
      ##1 requested_r == $past(next_send_r, 2)) else $error("requested seqnum wrong");
   count_up_a: assert property (unit_sent && !poll_now
      |=> units_cnt_r == $past(units_cnt_r) + 16'h0001 && !unit_poll)
      else $error("unit counter did not advance");
   seg_fit_a: assert property (seg_emit
      |=> seg_valid && seg_poll && 16'(seg_last - seg_first) < $past(room))
      else $error("segment exceeds grant");
   sequence s_so_report_load;
      rpt_load && nack_r && so_r;
   endsequence
   rpt_len_a: assert property (s_so_report_load
      |=> rpt_valid && !rpt_last && left_r == `HQ_BYTES_SO)
      else $error("report length not eight octets");
endmodule // hq_retx_ctrl
`default_nettype wire

// file: sim/hq_peer.sv
// Peer entity model that takes in status reports octet by octet.
`default_nettype none
module hq_peer (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clr,
   input wire logic [7:0] rpt_data,
   input wire logic rpt_valid,
   input wire logic rpt_last,
   output logic rpt_ready,
   output logic [63:0] rx_bits,
   output logic [3:0] rx_n,
   output logic rx_done
);
   timeunit 1ns;
   timeprecision 1ps;
   // Ready drops every third cycle, so an octet presented in a stall has to hold through it.
   logic [1:0] ph_r;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         ph_r <= 2'h0;
         rpt_ready <= 1'h0;
         {rx_bits, rx_n, rx_done} <= 69'h0;
      end else begin
         ph_r <= (ph_r == 2'h2) ? 2'h0 : ph_r + 2'h1;
         rpt_ready <= (ph_r != 2'h1);
         if (clr) begin
            {rx_bits, rx_n, rx_done} <= 69'h0;
         end else if (rpt_valid && rpt_ready) begin
            rx_bits <= {rx_bits[55:0], rpt_data};
            rx_n <= rx_n + 4'h1;
            rx_done <= rpt_last;
         end
      end
   end
endmodule // hq_peer
`default_nettype wire

// file: sim/test_harq_arq_retransmission_control.sv
// Self-checking bench for the retransmission control block.
`include "hq_defs.svh"
`default_nettype none
module test_harq_arq_retransmission_control import hq_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MAXR = 2;
   localparam int UTHR = 3;
   localparam int OTHR = 100;
   logic clk = '0, rst_b = '0, s_axi_awvalid = '0, s_axi_wvalid = '0, s_axi_bready = '0;
   logic s_axi_arvalid = '0, s_axi_rready = '0, harq_decide = '0, ul_grant_valid = '0;
   logic ul_grant_new = '0, ul_feedback_nack = '0, meas_gap = '0, dl_grant_valid = '0;
   logic dl_grant_retx = '0, dl_decode_done = '0, dl_decode_ok = '0, ul_data_sched = '0;
   logic unit_sent = '0, unit_bufs_empty = '0, unit_window_stall = '0, nack_from_report = '0;
   logic tx_opp = '0, rx_peer_poll = '0, rx_missing = '0, rx_missing_has_so = '0, peer_clr = '0;
   logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0, rpt_data;
   logic [31:0] s_axi_wdata = '0, s_axi_rdata, rd_d;
   logic [3:0] s_axi_wstrb = 4'hf, rx_n;
   logic [2:0] ul_grant_proc = '0, ul_sync_proc = '0, dl_grant_proc = '0;
   logic [15:0] unit_len = '0, tx_opp_octets = '0;
   logic [14:0] nack_first = '0, nack_last = '0, rx_so_first = '0, rx_so_last = '0;
   logic [9:0] rx_missing_sn = '0, rx_ack_seqnum = '0, unit_seqnum, sn = '0, rsn = '0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, ul_act_valid;
   logic dl_sched_valid, dl_sched_retx, dl_fb_valid, dl_fb_ack, dl_fb_on_extra, unit_poll;
   logic poll_timer_expired, seg_valid, seg_poll, rpt_valid, rpt_last, rpt_ready, rx_done;
   logic [1:0] s_axi_bresp, s_axi_rresp, rd_r;
   logic [2:0] ul_act_proc, dl_sched_proc;
   logic [14:0] seg_first, seg_last;
   logic [63:0] rx_bits;
   logic [31:0] rv [6] = '{32'h0, 32'(`HQ_RST_MAXRETX), 32'(`HQ_RST_UNITTHR),
      32'(`HQ_RST_OCTTHR), 32'(`HQ_RST_TMR), 32'(`HQ_RST_PROH)};
   hq_ul_act_t ul_act;
   int n_errors = 0, check_count = 0, cycles = 0, units = 0, octs = 0;
   int hcnt [8];
   always #5 clk = ~clk;
   hq_retx_ctrl u_dut (.*);
   hq_peer u_peer (.clk(clk), .rst_b(rst_b), .clr(peer_clr), .rpt_data(rpt_data),
      .rpt_valid(rpt_valid), .rpt_last(rpt_last), .rpt_ready(rpt_ready), .rx_bits(rx_bits),
      .rx_n(rx_n), .rx_done(rx_done));
   task automatic chk(input string n, input logic [71:0] e, input logic [71:0] g);
      check_count++;
      if (g !== e) begin
         n_errors++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic end_of_test();
      $display("errors %0d, checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'h7};
      do begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
      end while (s_axi_bvalid !== 1'h1);
      chk("write_resp", (a > `HQ_OFF_CNTST || a[1:0] != 2'h0) ? `HQ_RESP_ERR : `HQ_RESP_OK,
         s_axi_bresp);
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [7:0] a);
      @(posedge clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'h3};
      do begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
      end while (s_axi_rvalid !== 1'h1);
      {rd_r, rd_d} = {s_axi_rresp, s_axi_rdata};
      s_axi_rready <= 1'h0;
   endtask
   // Draws one uplink decision plus downlink grant and decode events in the same cycle.
   task automatic harq_step();
      logic [17:0] r;
      logic gv, gn, nk, gp, dv, dr, dd, dk, us;
      logic [2:0] gpr, sp, dp, p;
      hq_ul_act_t e;
      r = 18'($urandom);
      {gv, gn, nk, gp, gpr, sp, dv, dr, dp, dd, dk, us} = r;
      p = gv ? gpr : sp;
      if (gv) e = gn ? HQ_ACT_NEW : HQ_ACT_ADAPT;
      else e = (nk && hcnt[p] < MAXR) ? HQ_ACT_NONADAPT : HQ_ACT_HOLD;
      if (gp && e inside {HQ_ACT_ADAPT, HQ_ACT_NONADAPT}) e = HQ_ACT_SKIP;
      if (e == HQ_ACT_NEW) hcnt[p] = 0;
      if (e inside {HQ_ACT_ADAPT, HQ_ACT_NONADAPT}) hcnt[p]++;
      @(posedge clk);
      {harq_decide, ul_grant_valid, ul_grant_new, ul_feedback_nack, meas_gap, ul_grant_proc,
         ul_sync_proc, dl_grant_valid, dl_grant_retx, dl_grant_proc, dl_decode_done,
         dl_decode_ok, ul_data_sched} <= {1'h1, r};
      @(posedge clk);
      {harq_decide, dl_grant_valid, dl_decode_done} <= 3'h0;
      #1;
      chk("harq", {1'h1, e, p, dv, dv ? {dr, dp} : 4'h0, dd, dd ? {dk, us} : 2'h0},
         {ul_act_valid, ul_act, ul_act_proc, dl_sched_valid,
         dv ? {dl_sched_retx, dl_sched_proc} : 4'h0, dl_fb_valid,
         dd ? {dl_fb_ack, dl_fb_on_extra} : 2'h0});
   endtask
   task automatic send_unit(input logic be, input logic st);
      logic [15:0] len;
      logic pl;
      len = 16'($urandom_range(60, 1));
      pl = units >= UTHR || octs >= OTHR || be || st;
      @(posedge clk);
      {unit_sent, unit_len, unit_bufs_empty, unit_window_stall} <= {1'h1, len, be, st};
      @(posedge clk);
      {unit_sent, unit_bufs_empty, unit_window_stall} <= 3'h0;
      #1;
      chk("unit", {pl, sn}, {unit_poll, unit_seqnum});
      if (pl) rsn = sn;
      units = pl ? 0 : units + 1;
      octs = pl ? 0 : octs + len;
      sn++;
   endtask
   task automatic seg_opp(input logic [15:0] o, input logic [14:0] f, input logic [14:0] l);
      @(posedge clk);
      {tx_opp, tx_opp_octets} <= {1'h1, o};
      @(posedge clk);
      tx_opp <= 1'h0;
      #1;
      chk("segment", {1'h1, f, l, 1'h1}, {seg_valid, seg_first, seg_last, seg_poll});
   endtask
   task automatic report(input logic miss, input logic so, input logic [3:0] nb);
      logic [49:0] r;
      logic [63:0] e;
      r = 50'({$urandom, $urandom});
      e = {4'h0, r[49:40], miss, miss ? {r[39:30], 1'h0, so} : 12'h0, so ? r[29:0] : 30'h0, 7'h0};
      @(posedge clk);
      {peer_clr, rx_ack_seqnum, rx_missing_sn, rx_so_first, rx_so_last} <= {1'h1, r};
      {rx_missing_has_so, rx_peer_poll, rx_missing} <= {so, !miss, miss};
      @(posedge clk);
      {peer_clr, rx_peer_poll, rx_missing} <= 3'h0;
      for (int t = 0; t < 300; t++) begin
         @(posedge clk);
         if (rx_done === 1'h1) break;
      end
      #1;
      chk("report", {nb, e}, {rx_n, rx_bits << (64 - 8 * nb)});
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 8000) begin
         n_errors++;
         end_of_test();
      end
   end
   initial begin
      void'($urandom(32'hd587753e));
      repeat (8) @(posedge clk);
      rst_b <= 1'h1;
      foreach (rv[i]) begin
         rd(8'(4 * i));
         chk("reset_value", {`HQ_RESP_OK, rv[i]}, {rd_r, rd_d});
      end
      rd(8'h41);
      chk("unmapped", {`HQ_RESP_ERR, 32'h0}, {rd_r, rd_d});
      wr(`HQ_OFF_MAXRETX, 32'(MAXR));
      wr(`HQ_OFF_UNITTHR, 32'(UTHR));
      wr(`HQ_OFF_OCTTHR, 32'(OTHR));
      repeat (200) harq_step();
      for (int i = 0; i < 30; i++) send_unit(i % 9 == 8, i % 13 == 12);
      rd(`HQ_OFF_POLLST);
      chk("requested", rsn, rd_d[9:0]);
      rd(`HQ_OFF_CNTST);
      chk("counters", {units[15:0], octs[15:0]}, rd_d);
      wr(`HQ_OFF_TMR, 32'h0000_0008);
      wr(8'h42, 32'h0000_0000);
      send_unit(1'h1, 1'h0);
      repeat (7) @(posedge clk);
      #1;
      chk("timer_early", 1'h0, poll_timer_expired);
      @(posedge clk);
      #1;
      chk("timer_expired", 1'h1, poll_timer_expired);
      @(posedge clk);
      {nack_from_report, nack_first, nack_last} <= {1'h1, 15'h0, 15'h1d};
      @(posedge clk);
      nack_from_report <= 1'h0;
      seg_opp(16'he, 15'h0, 15'h9);
      seg_opp(16'h64, 15'ha, 15'h1d);
      rd(`HQ_OFF_POLLST);
      chk("seg_requested", sn - 10'h1, rd_d[9:0]);
      report(1'h0, 1'h0, 4'h2);
      report(1'h1, 1'h1, 4'h8);
      wr(`HQ_OFF_CTRL, 32'h0000_0001);
      report(1'h1, 1'h0, 4'h4);
      end_of_test();
   end
endmodule // test_harq_arq_retransmission_control
`default_nettype wire
